//--- logic/dts_engine.sv
// Dual timestamp engine: system time and oscillator driven insertion time
// How it works
// - Free 32-bit system time, never steered
// - Insertion time advanced by main loop oscillator
// - Insertion time counts in PTP, NTP or RTP
// - Both counters sampled on one clock edge
// - Arrivals stamped with system time
// - Departures stamped with insertion time, 1588 format
// - Oscillator steered by loop or CPU alike
// - Server inserts insertion time into sync messages
// - Seconds load, fraction cleared on next pps
// - System time runs on the system clock
// - Client opens loop, CPU sets centre frequency
// - Client frame pulse aligns to seconds rollover
// - Boundary engine inserting stamps, frame pulse not aligned (client only)
// - Hybrid: CPU overwrites absolute insertion time
`timescale 1ns/1ps
`default_nettype none
module dts_engine
   import dts_pkg::*;
#(
   parameter int unsigned FP_DIV = FP_CYCLES
) (
   // Clock, reset and enable
   input  wire logic                 clock,
   input  wire logic                 rst_b,
   input  wire logic                 clk_en,
   // Operating selection
   input  wire dts_pkg::dts_op_t     op_mode,
   input  wire dts_pkg::dts_fmt_t    fmt_sel,
   input  wire logic                 cpu_steer,
   // Oscillator steering
   input  wire logic [31:0]          loop_freq_word,
   input  wire logic [31:0]          cpu_freq_word,
   // CPU time writes
   input  wire logic                 sec_load,
   input  wire logic [31:0]          sec_value,
   input  wire logic                 time_write,
   input  wire logic [31:0]          time_sec,
   input  wire logic [31:0]          time_frac,
   // Alignment pulse pin
   input  wire logic                 pps_in,
   input  wire logic                 fp_align_en,
   // Packet events from the MAC ports
   input  wire logic                 rx_event,
   input  wire logic                 tx_event,
   input  wire logic                 tx_is_sync,
   // Live counters
   output logic [31:0]               sys_time,
   output logic [31:0]               ins_sec,
   output logic [31:0]               ins_frac,
   output logic                      align_armed,
   output logic                      align_done,
   // Snapshot pair
   output logic                      snap_valid,
   output logic [31:0]               snap_sys,
   output logic [31:0]               snap_sec,
   output logic [31:0]               snap_frac,
   // Packet stamps
   output logic                      rx_stamp_valid,
   output logic [31:0]               rx_stamp,
   output logic                      tx_stamp_valid,
   output logic [47:0]               tx_stamp_sec,
   output logic [31:0]               tx_stamp_ns,
   output logic                      sync_insert,
   // Frame pulse
   output logic                      frame_pulse
);
   import dts_pkg::*;
   // ---------------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------------
   logic [SYS_W-1:0]   sys_q;
   logic [SEC_W-1:0]   sec_q, sec_d;
   logic [FRAC_W-1:0]  frac_q, frac_d, frac_step;
   logic [PHASE_W:0]   phase_sum;
   logic [PHASE_W-1:0] phase_q, freq_word;
   logic [FRAC_W:0]    frac_sum;
   logic               dco_tick, sec_roll, pps_rise, serving;
   logic               pps_meta_q, pps_sync_q, pps_last_q;
   dts_align_t         align_q;
   logic [31:0]        pend_sec_q, samp_cnt_q, fp_cnt_q;
   logic               fp_q, done_q, snap_v_q, rx_v_q, tx_v_q, ins_q;
   logic [31:0]        snap_sys_q, snap_sec_q, snap_frac_q, rx_q, tx_ns_q;
   logic [47:0]        tx_sec_q;
   // ---------------------------------------------------------------------
   // System time
   // ---------------------------------------------------------------------
   // Free counter on the system clock, no steering input at all
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sys_q <= SYS_RESET;
      end else if (clk_en) begin
         sys_q <= sys_q + 32'h00000001;
      end
   end

   // ---------------------------------------------------------------------
   // Oscillator
   // ---------------------------------------------------------------------
   // Same accumulator whichever source steers it
   assign freq_word = (cpu_steer || op_mode == DTS_OP_CLIENT) ?
                      cpu_freq_word : loop_freq_word;

   assign phase_sum = {1'b0, phase_q} + {1'b0, freq_word};
   assign dco_tick  = phase_sum[PHASE_W];

   // Phase accumulator, carry out is one oscillator tick
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         phase_q <= FREQ_RESET;
      end else if (clk_en) begin
         phase_q <= phase_sum[PHASE_W-1:0];
      end
   end

   // ---------------------------------------------------------------------
   // Pps synchroniser and edge detect
   // ---------------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pps_meta_q <= 1'b0;
         pps_sync_q <= 1'b0;
         pps_last_q <= 1'b0;
      end else if (clk_en) begin
         pps_meta_q <= pps_in;
         pps_sync_q <= pps_meta_q;
         pps_last_q <= pps_sync_q;
      end
   end

   assign pps_rise = pps_sync_q && !pps_last_q;

   // ---------------------------------------------------------------------
   // Insertion time next value
   // ---------------------------------------------------------------------
   // Step and rollover follow the selected protocol format
   always_comb begin
      case (fmt_sel)
         DTS_FMT_NTP: frac_step = NTP_STEP;
         DTS_FMT_RTP: frac_step = RTP_STEP;
         default:     frac_step = PTP_NS_STEP;
      endcase
   end

   assign frac_sum = {1'b0, frac_q} + {1'b0, frac_step};

   always_comb begin
      sec_d    = sec_q;
      frac_d   = frac_q;
      sec_roll = 1'b0;
      if (dco_tick) begin
         case (fmt_sel)
            DTS_FMT_NTP: begin
               frac_d   = frac_sum[FRAC_W-1:0];
               sec_roll = frac_sum[FRAC_W];
            end
            DTS_FMT_RTP: frac_d = frac_sum[FRAC_W-1:0];
            default: begin
               if (frac_sum[FRAC_W-1:0] >= PTP_NS_LIMIT) begin
                  frac_d   = frac_sum[FRAC_W-1:0] - PTP_NS_LIMIT;
                  sec_roll = 1'b1;
               end else begin
                  frac_d = frac_sum[FRAC_W-1:0];
               end
            end
         endcase
         if (sec_roll) begin
            sec_d = sec_q + 32'h00000001;
         end
      end
      // Pps clears the fraction, unless a new load replaces the seconds
      if (align_q == DTS_AL_ARMED && pps_rise && !sec_load) begin
         sec_d    = pend_sec_q;
         frac_d   = FRAC_RESET;
         sec_roll = 1'b1;
      end
      // Absolute overwrite wins over counting
      if (time_write) begin
         sec_d  = time_sec;
         frac_d = time_frac;
      end
   end

   // Insertion time registers
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sec_q  <= SEC_RESET;
         frac_q <= FRAC_RESET;
      end else if (clk_en) begin
         sec_q  <= sec_d;
         frac_q <= frac_d;
      end
   end

   // ---------------------------------------------------------------------
   // Seconds alignment sequence
   // ---------------------------------------------------------------------
   // Seconds are held until the pps edge so both land in one second
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         align_q    <= DTS_AL_IDLE;
         pend_sec_q <= SEC_RESET;
         done_q     <= 1'b0;
      end else if (clk_en) begin
         done_q <= 1'b0;
         case (align_q)
            DTS_AL_ARMED: begin
               if (sec_load) begin
                  pend_sec_q <= sec_value;
               end else if (time_write) begin
                  align_q <= DTS_AL_IDLE;
               end else if (pps_rise) begin
                  done_q  <= 1'b1;
                  align_q <= DTS_AL_DONE;
               end
            end
            // Idle or just done: a load arms again, never lost
            default: begin
               if (sec_load) begin
                  pend_sec_q <= sec_value;
                  align_q    <= DTS_AL_ARMED;
               end else begin
                  align_q <= DTS_AL_IDLE;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------------
   // Simultaneous sampling
   // ---------------------------------------------------------------------
   // Both counters caught on the same edge and held as one pair
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         samp_cnt_q  <= 32'h00000000;
         snap_v_q    <= 1'b0;
         snap_sys_q  <= SYS_RESET;
         snap_sec_q  <= SEC_RESET;
         snap_frac_q <= FRAC_RESET;
      end else if (clk_en) begin
         snap_v_q <= 1'b0;
         if (samp_cnt_q == SAMPLE_CYCLES - 1) begin
            samp_cnt_q  <= 32'h00000000;
            snap_v_q    <= 1'b1;
            snap_sys_q  <= sys_q;
            snap_sec_q  <= sec_q;
            snap_frac_q <= frac_q;
         end else begin
            samp_cnt_q <= samp_cnt_q + 32'h00000001;
         end
      end
   end

   // ---------------------------------------------------------------------
   // Packet stamps
   // ---------------------------------------------------------------------
   // Arrivals always in system time
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rx_v_q <= 1'b0;
         rx_q   <= SYS_RESET;
      end else if (clk_en) begin
         rx_v_q <= rx_event;
         if (rx_event) begin
            rx_q <= sys_q;
         end
      end
   end

   assign serving = op_mode == DTS_OP_SERVER || op_mode == DTS_OP_BOUNDARY
                    || op_mode == DTS_OP_HYBRID;

   // Departures in insertion time, 48-bit seconds and nanoseconds
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         tx_v_q   <= 1'b0;
         tx_sec_q <= 48'h000000000000;
         tx_ns_q  <= FRAC_RESET;
         ins_q    <= 1'b0;
      end else if (clk_en) begin
         tx_v_q <= tx_event;
         ins_q  <= tx_event && tx_is_sync && serving;
         if (tx_event) begin
            tx_sec_q <= {16'h0000, sec_q};
            tx_ns_q  <= frac_q;
         end
      end
   end

   // ---------------------------------------------------------------------
   // One hertz frame pulse
   // ---------------------------------------------------------------------
   // Free divider, or the insertion seconds rollover when aligned
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         fp_cnt_q <= 32'h00000000;
         fp_q     <= 1'b0;
      end else if (clk_en) begin
         if (fp_align_en && op_mode == DTS_OP_CLIENT) begin
            fp_cnt_q <= 32'h00000000;
            fp_q     <= sec_roll || (sec_d != sec_q);
         end else if (fp_cnt_q == FP_DIV - 1) begin
            fp_cnt_q <= 32'h00000000;
            fp_q     <= 1'b1;
         end else begin
            fp_cnt_q <= fp_cnt_q + 32'h00000001;
            fp_q     <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------------
   assign sys_time       = sys_q;
   assign ins_sec        = sec_q;
   assign ins_frac       = frac_q;
   assign align_armed    = align_q == DTS_AL_ARMED;
   assign align_done     = done_q;
   assign snap_valid     = snap_v_q;
   assign snap_sys       = snap_sys_q;
   assign snap_sec       = snap_sec_q;
   assign snap_frac      = snap_frac_q;
   assign rx_stamp_valid = rx_v_q;
   assign rx_stamp       = rx_q;
   assign tx_stamp_valid = tx_v_q;
   assign tx_stamp_sec   = tx_sec_q;
   assign tx_stamp_ns    = tx_ns_q;
   assign sync_insert    = ins_q;
   assign frame_pulse    = fp_q;
endmodule : dts_engine
`default_nettype wire

//--- logic/dts_pkg.sv
// Constants and types shared by the dual timestamp engine
`default_nettype none
package dts_pkg;
   // -------------------------------------------------------------------
   // Clock and timing
   // -------------------------------------------------------------------
   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
   localparam int unsigned SAMPLE_PERIOD_US = 100;
   localparam int unsigned SAMPLE_CYCLES   =
      SAMPLE_PERIOD_US * (CLK_HZ / 1_000_000);
   localparam int unsigned FP_PERIOD_S     = 1;
   localparam int unsigned FP_CYCLES       = FP_PERIOD_S * CLK_HZ;

   // -------------------------------------------------------------------
   // Field widths and reset values
   // -------------------------------------------------------------------
   localparam int unsigned SYS_W   = 32;
   localparam int unsigned SEC_W   = 32;
   localparam int unsigned FRAC_W  = 32;
   localparam int unsigned PHASE_W = 32;
   localparam int unsigned PTP_SEC_W = 48;
   localparam logic [SYS_W-1:0]   SYS_RESET  = 32'h00000000;
   localparam logic [SEC_W-1:0]   SEC_RESET  = 32'h00000000;
   localparam logic [FRAC_W-1:0]  FRAC_RESET = 32'h00000000;
   localparam logic [PHASE_W-1:0] FREQ_RESET = 32'h80000000;

   // -------------------------------------------------------------------
   // Fraction steps per oscillator tick and rollover limits
   // -------------------------------------------------------------------
   localparam logic [FRAC_W-1:0] PTP_NS_LIMIT = 32'h3B9ACA00;
   localparam logic [FRAC_W-1:0] PTP_NS_STEP  = 32'h00000064;
   localparam logic [FRAC_W-1:0] NTP_STEP     = 32'h000001AE;
   localparam logic [FRAC_W-1:0] RTP_STEP     = 32'h00000001;

   // -------------------------------------------------------------------
   // Enumerations
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      DTS_FMT_PTP,
      DTS_FMT_NTP,
      DTS_FMT_RTP
   } dts_fmt_t;

   typedef enum logic [1:0] {
      DTS_OP_SERVER,
      DTS_OP_CLIENT,
      DTS_OP_BOUNDARY,
      DTS_OP_HYBRID
   } dts_op_t;

   typedef enum logic [1:0] {
      DTS_AL_IDLE,
      DTS_AL_ARMED,
      DTS_AL_DONE
   } dts_align_t;
endpackage : dts_pkg
`default_nettype wire

//--- tb/dts_engine_asserts.sv
// Port checker for the dual timestamp engine
`timescale 1ns/1ps
`default_nettype none
module dts_engine_asserts
   import dts_pkg::*;
#(
   parameter int unsigned FP_DIV = FP_CYCLES
) (
   // Clock, reset and controls
   input wire logic              clock,
   input wire logic              rst_b,
   input wire logic              clk_en,
   input wire dts_pkg::dts_op_t  op_mode,
   input wire logic              cpu_steer,
   input wire logic [31:0]       cpu_freq_word,
   input wire logic              sec_load,
   input wire logic              time_write,
   input wire logic [31:0]       time_sec,
   input wire logic [31:0]       time_frac,
   input wire logic              fp_align_en,
   input wire logic              rx_event,
   input wire logic              tx_event,
   input wire logic              tx_is_sync,
   // Observed outputs
   input wire logic [31:0]       sys_time,
   input wire logic [31:0]       ins_sec,
   input wire logic [31:0]       ins_frac,
   input wire logic              align_armed,
   input wire logic              align_done,
   input wire logic              snap_valid,
   input wire logic [31:0]       snap_sys,
   input wire logic [31:0]       snap_sec,
   input wire logic [31:0]       snap_frac,
   input wire logic              rx_stamp_valid,
   input wire logic [31:0]       rx_stamp,
   input wire logic              tx_stamp_valid,
   input wire logic [47:0]       tx_stamp_sec,
   input wire logic [31:0]       tx_stamp_ns,
   input wire logic              sync_insert,
   input wire logic              frame_pulse
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   // Counter, stamps and insertion checks
   a_sys_time_inc: assert property (
      clk_en |=> sys_time == $past(sys_time) + 32'h1)
      else $error("system time did not advance by one");
   a_rx_stamp_val: assert property (
      clk_en && rx_event |=> rx_stamp_valid && rx_stamp == $past(sys_time))
      else $error("arrival stamp wrong");
   a_tx_stamp_val: assert property (
      clk_en && tx_event |=> tx_stamp_valid
      && tx_stamp_ns == $past(ins_frac)
      && tx_stamp_sec == {16'h0000, $past(ins_sec)})
      else $error("departure stamp wrong");
   a_sync_ins_mode: assert property (
      clk_en |=> sync_insert ==
      $past(tx_event && tx_is_sync && op_mode != DTS_OP_CLIENT))
      else $error("sync insertion wrong");
   a_snap_pair_hold: assert property (
      !snap_valid |-> $stable(snap_sys)
      && $stable(snap_sec) && $stable(snap_frac))
      else $error("snapshot changed between samples");
   a_align_frac_clr: assert property (
      align_done && clk_en
      |-> ins_frac == FRAC_RESET && !align_armed ##1 !align_done)
      else $error("alignment did not clear fraction");
   a_align_arm_set: assert property (
      clk_en && sec_load && !time_write |=> align_armed)
      else $error("seconds load did not arm");
   a_time_write_ld: assert property (
      clk_en && time_write
      |=> ins_sec == $past(time_sec) && ins_frac == $past(time_frac))
      else $error("time write not applied");
   a_osc_cpu_hold: assert property (
      clk_en && cpu_freq_word == 32'h0
      && (cpu_steer || op_mode == DTS_OP_CLIENT) && !time_write
      && !align_armed |=> $stable(ins_frac))
      else $error("insertion time moved with zero frequency");
   a_fp_sec_align: assert property (
      $past(clk_en && op_mode == DTS_OP_CLIENT && fp_align_en)
      && $changed(ins_sec) |-> frame_pulse)
      else $error("frame pulse not aligned to seconds");

   // Main scenarios reached
   c_snap:  cover property (snap_valid);
   c_align: cover property (align_done);
   c_sync:  cover property (sync_insert);
endmodule : dts_engine_asserts

bind dts_engine dts_engine_asserts #(.FP_DIV(FP_DIV)) u_chk (.*);
`default_nettype wire

//--- tb/dts_far_model.sv
// Far side model: alignment pulse source of the time reference
`timescale 1ns/1ps
`default_nettype none
module dts_far_model (
   // Clock and request
   input  wire logic clock,
   input  wire logic pps_req,
   // Alignment pulse pin
   output var  logic pps_in
);
   int cnt = 0;
   initial pps_in = 1'b0;
   // Ten cycle high pulse a few cycles after each request taken while idle
   always @(posedge clock) begin
      if (pps_req && cnt == 0) cnt = 14;
      if (cnt > 0) cnt = cnt - 1;
      #2;
      pps_in = (cnt > 0 && cnt < 11);
   end
endmodule : dts_far_model
`default_nettype wire

//--- tb/tb_dual_timestamp_engine.sv
// Self-checking bench for the dual timestamp engine
`timescale 1ns/1ps
`default_nettype none
module tb_dual_timestamp_engine;
   import dts_pkg::*;
   logic clock = 0, rst_b = 0, clk_en = 1, cpu_steer = 1, pps_req = 0;
   logic sec_load = 0, time_write = 0, fp_align_en = 0, pps_in;
   logic rx_event = 0, tx_event = 0, tx_is_sync = 0;
   logic [31:0] loop_freq_word = 0, cpu_freq_word = 0, sec_value = 0;
   logic [31:0] time_sec = 0, time_frac = 0, exp_sec, exp_frac, v, sys_m;
   dts_op_t     op_mode = DTS_OP_SERVER;
   dts_fmt_t    fmt_sel = DTS_FMT_PTP;
   logic [31:0] sys_time, ins_sec, ins_frac, snap_sys, snap_sec, snap_frac;
   logic [31:0] rx_stamp, tx_stamp_ns;
   logic [47:0] tx_stamp_sec;
   logic align_armed, align_done, snap_valid, rx_stamp_valid;
   logic tx_stamp_valid, sync_insert, frame_pulse;
   logic [80:0] rx_q[$], tx_q[$];
   int num_errors = 0, n_tests = 0;

   dts_engine #(.FP_DIV(50)) dut_u (.clock(clock), .rst_b(rst_b),
      .clk_en(clk_en), .op_mode(op_mode), .fmt_sel(fmt_sel),
      .cpu_steer(cpu_steer), .loop_freq_word(loop_freq_word),
      .cpu_freq_word(cpu_freq_word), .sec_load(sec_load),
      .sec_value(sec_value), .time_write(time_write), .time_sec(time_sec),
      .time_frac(time_frac), .pps_in(pps_in), .fp_align_en(fp_align_en),
      .rx_event(rx_event), .tx_event(tx_event), .tx_is_sync(tx_is_sync),
      .sys_time(sys_time), .ins_sec(ins_sec), .ins_frac(ins_frac),
      .align_armed(align_armed), .align_done(align_done),
      .snap_valid(snap_valid), .snap_sys(snap_sys), .snap_sec(snap_sec),
      .snap_frac(snap_frac), .rx_stamp_valid(rx_stamp_valid),
      .rx_stamp(rx_stamp), .tx_stamp_valid(tx_stamp_valid),
      .tx_stamp_sec(tx_stamp_sec), .tx_stamp_ns(tx_stamp_ns),
      .sync_insert(sync_insert), .frame_pulse(frame_pulse));
   dts_far_model u_far (.clock(clock), .pps_req(pps_req), .pps_in(pps_in));

   // 50 ns system clock
   initial forever #25 clock = ~clock;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [80:0] seen, input logic [80:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   task automatic stop_test();
      if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask : step
   task automatic wr(input logic [31:0] s, input logic [31:0] f);
      time_write = 1;
      time_sec = s;
      time_frac = f;
      exp_sec = s;
      exp_frac = f;
      step(1);
      time_write = 0;
   endtask : wr
   function automatic logic pick(input int s);
      case (s)
         0: return align_done;
         1: return snap_valid;
         default: return frame_pulse;
      endcase
   endfunction : pick
   task automatic wait_pulse(input int s, input int lim);
      int k;
      k = 0;
      while (pick(s) !== 1'b1) begin
         step(1);
         k++;
         if (k > lim) begin
            num_errors++;
            stop_test();
         end
      end
   endtask : wait_pulse

   // Expected stamps noted at each taking edge
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) sys_m <= 32'h0;
      else if (clk_en) begin
         if (rx_event) rx_q.push_back(81'(sys_m));
         if (tx_event) tx_q.push_back({tx_is_sync &&
            op_mode != DTS_OP_CLIENT, 16'h0000, exp_sec, exp_frac});
         sys_m <= sys_m + 32'h1;
      end
   end

   // Stamps compared oldest first, only on enabled edges
   always @(posedge clock) begin
      #1;
      if (clk_en === 1'b1 && rx_stamp_valid === 1'b1)
         chk(81'(rx_stamp), rx_q.pop_front());
      if (clk_en === 1'b1 && tx_stamp_valid === 1'b1)
         chk({sync_insert, tx_stamp_sec, tx_stamp_ns},
             tx_q.pop_front());
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(26964));
      step(3);
      rst_b = 1;
      wr(32'h12, 32'h1234);
      chk(81'({ins_sec, ins_frac}), 81'({exp_sec, exp_frac}));
      // Random traffic, loop steering ignored while CPU steers
      for (int i = 0; i < 240; i++) begin
         rx_event = $urandom % 2;
         clk_en = ($urandom % 4) != 0;
         loop_freq_word = $urandom;
         tx_event = (i % 3) == 0;
         tx_is_sync = $urandom % 2;
         op_mode = dts_op_t'(i % 4);
         step(1);
      end
      {rx_event, tx_event, clk_en} = 3'b001;
      op_mode = DTS_OP_SERVER;
      step(2);
      // One tick per cycle in each format, across the seconds boundary in PTP and NTP
      for (int f = 0; f < 3; f++) begin
         fmt_sel = dts_fmt_t'(f);
         cpu_freq_word = 32'hFFFFFFFF;
         v = (f == 0) ? PTP_NS_LIMIT - 32'hC8 : (f == 1) ? 32'hFFFFFF00 : 5;
         wr(32'h7, v);
         step(3);
         cpu_freq_word = 0;
         if (f == 0) v = 32'h64;
         else v = v + 3 * ((f == 1) ? NTP_STEP : RTP_STEP);
         chk(81'({ins_sec, ins_frac}),
             81'({(f == 2) ? 32'h7 : 32'h8, v}));
      end
      // Client: loop opened, CPU word governs
      op_mode = DTS_OP_CLIENT;
      cpu_steer = 1'b0;
      loop_freq_word = 32'hFFFFFFFF;
      step(5);
      chk(81'(ins_frac), 81'(v));
      // Seconds load then fraction cleared at the pulse
      op_mode = DTS_OP_SERVER;
      cpu_steer = 1'b1;
      sec_value = $urandom;
      sec_load = 1;
      step(1);
      sec_load = 0;
      chk(81'(align_armed), 81'h1);
      pps_req = 1;
      step(1);
      pps_req = 0;
      wait_pulse(0, 20);
      chk(81'({ins_sec, ins_frac}), 81'({sec_value, 32'h0}));
      step(20);
      chk(81'(ins_sec), 81'(sec_value));
      // Time write cancels a pending alignment
      sec_load = 1;
      step(1);
      sec_load = 0;
      wr(32'h55, 32'h99);
      chk(81'(align_armed), 81'h0);
      pps_req = 1;
      step(1);
      pps_req = 0;
      step(12);
      chk(81'({ins_sec, ins_frac}), 81'({32'h55, 32'h99}));
      // Coherent snapshot held until the next sample
      wait_pulse(1, 2100);
      chk(81'(snap_sys), 81'(SAMPLE_CYCLES - 1));
      chk(81'(sys_time), 81'(sys_m));
      step(1);
      chk({snap_sec, snap_frac}, {exp_sec, exp_frac});
      // Client frame pulse follows the seconds change
      op_mode = DTS_OP_CLIENT;
      fp_align_en = 1'b1;
      step(2);
      wr(32'h56, 32'h0);
      chk(81'(frame_pulse), 81'h1);
      step(1);
      chk(81'(frame_pulse), 81'h0);
      stop_test();
   end
endmodule : tb_dual_timestamp_engine
`default_nettype wire
